// [core/sdram_init_cfg.svh]
// Constants for the mode register and power-up sequence tracking logic.
// Assumes it is included by the package and the design modules only.
`ifndef SDRAM_INIT_CFG_SVH
`define SDRAM_INIT_CFG_SVH

// Address and bank widths
`define ADDR_W 14
`define BANK_W 3
// Bank codes that select the mode registers
`define BA_MR 3'h0
`define BA_EMR1 3'h1
`define BA_EMR2 3'h2
`define BA_EMR3 3'h3
// Operating mode register field positions
`define MR_BL_LSB 0
`define MR_BT_BIT 3
`define MR_CL_LSB 4
`define MR_TM_BIT 7
`define MR_DLLRST_BIT 8
`define MR_WR_LSB 9
// Burst length codes
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
// Lowest legal whole-clock latency code
`define CL_CODE_MIN 3'h2
// Extended register 1 fields
`define EMR1_DLL_BIT 0
`define EMR1_OCD_LSB 7
`define OCD_EXIT 3'h0
`define OCD_DEFAULT 3'h7
// Precharge-all flag
`define A10_BIT 10
// Link clocks from DLL reset until the DLL is usable
`define DLL_LOCK_CLKS 8'hC8
// Auto refreshes needed before the operating write
`define REFRESH_MIN 2'h2

`endif

// [core/sdram_init_pkg.sv]
// Types for the mode register and power-up sequence tracking logic.
// Assumes sdram_init_cfg.svh is reachable on the include path.
`include "sdram_init_cfg.svh"

package sdram_init_pkg;

  // Command, bank and address pins as seen on one link clock edge
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`BANK_W-1:0] ba;
    logic [`ADDR_W-1:0] addr;
  } cmd_pins_s;

  // Steps of the power-up sequence
  typedef enum logic [9:0] {
    ST_CKE_LOW  = 10'h001,
    ST_PREA1    = 10'h002,
    ST_EMR2     = 10'h004,
    ST_EMR3     = 10'h008,
    ST_EMR1     = 10'h010,
    ST_MR_DLL   = 10'h020,
    ST_PREA2    = 10'h040,
    ST_REFRESH  = 10'h080,
    ST_OCD      = 10'h100,
    ST_READY    = 10'h200
  } init_state_e;

  // State of the link sampler
  typedef struct packed {
    logic clk_q1;
    logic clk_q2;
    logic clk_q3;
    cmd_pins_s pins_q1;
    cmd_pins_s pins_q2;
    logic vld;
    cmd_pins_s pins;
  } sampler_s;

  // State of the mode register block
  typedef struct packed {
    init_state_e st;
    logic [`ADDR_W-1:0] mode_reg;
    logic [`ADDR_W-1:0] emr1;
    logic [`ADDR_W-1:0] emr2;
    logic [`ADDR_W-1:0] emr3;
    logic [1:0] ref_cnt;
    logic [7:0] dll_cnt;
    logic dll_ready;
    logic ocd_dflt;
    logic init_done;
    logic seq_error;
    logic bad_mode;
  } mode_s;

endpackage : sdram_init_pkg

// [core/link_sampler.sv]
// Samples the link clock and command pins in the system clock domain.
// Assumes the link clock is slow enough that pins hold across its edge.
`timescale 1ns/100ps
`include "sdram_init_cfg.svh"

module link_sampler (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Link side pins
  input wire logic link_clk,
  input wire sdram_init_pkg::cmd_pins_s pins_in,
  // Captured command, one pulse per link rising edge
  output logic smp_vld,
  output sdram_init_pkg::cmd_pins_s smp_pins
);

  sdram_init_pkg::sampler_s s_r; // Registered state
  sdram_init_pkg::sampler_s s_nxt; // Next state

  // Two-stage synchronisers, then edge detect on the second stage
  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_q1 = link_clk;
    s_nxt.clk_q2 = s_r.clk_q1;
    s_nxt.clk_q3 = s_r.clk_q2;
    s_nxt.pins_q1 = pins_in;
    s_nxt.pins_q2 = s_r.pins_q1;
    s_nxt.vld = s_r.clk_q2 & ~s_r.clk_q3;
    // Hold last capture between edges
    if (s_r.clk_q2 & ~s_r.clk_q3) begin
      s_nxt.pins = s_r.pins_q2;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign smp_vld = s_r.vld;
  assign smp_pins = s_r.pins;

endmodule : link_sampler

// [core/sdram_mode_ctrl.sv]
// Mode register capture and power-up sequence tracking of the memory.
// Assumes the controller drives the link clock and command pins.
`timescale 1ns/100ps
`include "sdram_init_cfg.svh"

module sdram_mode_ctrl (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Link pins from the controller
  input wire logic link_clk,
  input wire sdram_init_pkg::cmd_pins_s pins_in,
  // Decoded operating mode
  output logic [`ADDR_W-1:0] mode_reg,
  output logic burst_len8,
  output logic burst_interleave,
  output logic [2:0] cas_latency,
  output logic [2:0] write_recovery,
  output logic test_mode,
  output logic bad_mode,
  // Extended register one state
  output logic dll_enabled,
  output logic [2:0] ocd_mode,
  // Sequence status
  output logic dll_ready,
  output logic init_done,
  output logic seq_error
);

  logic smp_vld; // One pulse per link rising edge
  sdram_init_pkg::cmd_pins_s p; // Command captured on that edge
  sdram_init_pkg::mode_s s_r; // Registered state
  sdram_init_pkg::mode_s s_nxt; // Next state
  logic cmd_live; // Chip selected with CKE high
  logic mrs; // Any mode or extended register write
  logic mr_wr; // Operating mode register write
  logic prea; // Precharge all
  logic aref; // Auto refresh
  logic nop; // NOP or deselect

  // Matches the command code on RAS, CAS and WE
  function automatic logic cmd_is(input sdram_init_pkg::cmd_pins_s c,
                                  input logic [2:0] code);
    cmd_is = ({c.ras_n, c.cas_n, c.we_n} == code);
  endfunction : cmd_is

  // Burst length and latency codes that the device accepts
  function automatic logic mode_ok(input logic [`ADDR_W-1:0] v);
    mode_ok = (v[`MR_BL_LSB +: 3] == `BL_CODE_4 ||
               v[`MR_BL_LSB +: 3] == `BL_CODE_8) &&
              (v[`MR_CL_LSB +: 3] >= `CL_CODE_MIN);
  endfunction : mode_ok

  // Pin sampler in the system clock domain
  link_sampler u_sampler (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .link_clk(link_clk),
    .pins_in(pins_in),
    .smp_vld(smp_vld),
    .smp_pins(p)
  );

  // Command decode from the captured pins
  assign cmd_live = smp_vld & p.cke & ~p.cs_n;
  assign mrs = cmd_live & cmd_is(p, 3'h0);
  assign mr_wr = mrs & (p.ba == `BA_MR);
  assign prea = cmd_live & cmd_is(p, 3'h2) & p.addr[`A10_BIT];
  assign aref = cmd_live & cmd_is(p, 3'h1);
  assign nop = ~(smp_vld & p.cke) | p.cs_n | cmd_is(p, 3'h7);

  // Register capture and sequence tracking
  always_comb begin
    s_nxt = s_r;
    // DLL settle counter runs on link clocks
    if (smp_vld && !s_r.dll_ready) begin
      if (s_r.dll_cnt == `DLL_LOCK_CLKS - 8'h01) begin
        s_nxt.dll_ready = 1'b1;
      end else begin
        s_nxt.dll_cnt = s_r.dll_cnt + 8'h01;
      end
    end
    // Writes only touch the registers, never stored data
    if (mrs) begin
      unique case (p.ba)
        `BA_MR: begin
          s_nxt.mode_reg = p.addr;
          s_nxt.bad_mode = ~mode_ok(p.addr) | p.addr[`MR_TM_BIT];
          if (p.addr[`MR_DLLRST_BIT]) begin
            s_nxt.dll_cnt = 8'h00;
            s_nxt.dll_ready = 1'b0;
          end
        end
        `BA_EMR1: s_nxt.emr1 = p.addr;
        `BA_EMR2: s_nxt.emr2 = p.addr;
        `BA_EMR3: s_nxt.emr3 = p.addr;
        default: s_nxt.seq_error = 1'b1; // Unused bank codes
      endcase
    end
    // Power-up sequence, a stray command flags an error from ST_PREA1 to ST_OCD
    unique case (s_r.st)
      sdram_init_pkg::ST_CKE_LOW: begin
        if (smp_vld && p.cke) begin
          s_nxt.st = sdram_init_pkg::ST_PREA1;
        end
      end
      sdram_init_pkg::ST_PREA1: begin
        if (prea) begin
          s_nxt.st = sdram_init_pkg::ST_EMR2;
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_EMR2: begin
        if (mrs && p.ba == `BA_EMR2) begin
          s_nxt.st = sdram_init_pkg::ST_EMR3;
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_EMR3: begin
        if (mrs && p.ba == `BA_EMR3) begin
          s_nxt.st = sdram_init_pkg::ST_EMR1;
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_EMR1: begin
        if (mrs && p.ba == `BA_EMR1 && !p.addr[`EMR1_DLL_BIT]) begin
          s_nxt.st = sdram_init_pkg::ST_MR_DLL;
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_MR_DLL: begin
        if (mr_wr && p.addr[`MR_DLLRST_BIT]) begin
          s_nxt.st = sdram_init_pkg::ST_PREA2;
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_PREA2: begin
        if (prea) begin
          s_nxt.st = sdram_init_pkg::ST_REFRESH;
          s_nxt.ref_cnt = 2'h0;
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_REFRESH: begin
        if (aref) begin
          if (s_r.ref_cnt != 2'h3) begin
            s_nxt.ref_cnt = s_r.ref_cnt + 2'h1;
          end
        end else if (mr_wr && !p.addr[`MR_DLLRST_BIT] &&
                     s_r.ref_cnt >= `REFRESH_MIN) begin
          s_nxt.st = sdram_init_pkg::ST_OCD;
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_OCD: begin
        if (mrs && p.ba == `BA_EMR1) begin
          if (!s_r.dll_ready) begin
            s_nxt.seq_error = 1'b1;
          end
          if (p.addr[`EMR1_OCD_LSB +: 3] == `OCD_DEFAULT) begin
            s_nxt.ocd_dflt = 1'b1;
          end else if (p.addr[`EMR1_OCD_LSB +: 3] == `OCD_EXIT &&
                       s_r.ocd_dflt) begin
            s_nxt.st = sdram_init_pkg::ST_READY;
            s_nxt.init_done = 1'b1;
          end
        end else if (!nop) begin
          s_nxt.seq_error = 1'b1;
        end
      end
      sdram_init_pkg::ST_READY: begin
        s_nxt.init_done = 1'b1; // Re-init writes keep data
      end
    endcase
  end

  // State register, registers start undefined so they reset to zero, except the step, which resets to ST_CKE_LOW
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{st: sdram_init_pkg::ST_CKE_LOW, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Field outputs straight from the stored registers
  assign mode_reg = s_r.mode_reg;
  assign burst_len8 = (s_r.mode_reg[`MR_BL_LSB +: 3] == `BL_CODE_8);
  assign burst_interleave = s_r.mode_reg[`MR_BT_BIT];
  assign cas_latency = s_r.mode_reg[`MR_CL_LSB +: 3];
  assign write_recovery = s_r.mode_reg[`MR_WR_LSB +: 3];
  assign test_mode = s_r.mode_reg[`MR_TM_BIT];
  assign bad_mode = s_r.bad_mode;
  assign dll_enabled = ~s_r.emr1[`EMR1_DLL_BIT];
  assign ocd_mode = s_r.emr1[`EMR1_OCD_LSB +: 3];
  assign dll_ready = s_r.dll_ready;
  assign init_done = s_r.init_done;
  assign seq_error = s_r.seq_error;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_mode_capture: assert property (mr_wr |=> mode_reg == $past(p.addr))
    else $error("mode register not captured");
  a_burst_field: assert property (mr_wr |=>
      burst_len8 == ($past(p.addr[2:0]) == 3'h3) &&
      burst_interleave == $past(p.addr[3]))
    else $error("burst fields wrong");
  a_cas_field: assert property (mr_wr |=>
      cas_latency == $past(p.addr[6:4]) &&
      write_recovery == $past(p.addr[11:9]))
    else $error("latency or recovery wrong");
  a_dll_restart: assert property (mr_wr && p.addr[8] |=> !dll_ready)
    else $error("dll reset did not clear ready");
  a_dll_settle: assert property ($rose(dll_ready) |->
      $past(smp_vld) && $past(s_r.dll_cnt) == 8'hC7)
    else $error("dll ready at wrong count");
  a_prea_order: assert property (s_r.st == sdram_init_pkg::ST_PREA1 &&
      smp_vld && p.cke && !p.cs_n && !p.ras_n && !p.cas_n
      |=> seq_error)
    else $error("stray command not flagged");
  a_refresh_count: assert property ($changed(s_r.st) &&
      s_r.st == sdram_init_pkg::ST_OCD |-> $past(s_r.ref_cnt) >= 2'h2)
    else $error("left refresh step too early");
  a_done_path: assert property ($rose(init_done) |->
      $past(s_r.st) == sdram_init_pkg::ST_OCD && $past(s_r.ocd_dflt))
    else $error("init done without calibration exit");
  a_ocd_early: assert property (s_r.st == sdram_init_pkg::ST_OCD &&
      mrs && p.ba == 3'h1 && !dll_ready |=> seq_error)
    else $error("early calibration not flagged");
  a_error_sticky: assert property (seq_error |=> seq_error)
    else $error("error flag dropped");

endmodule : sdram_mode_ctrl

// [testbench/ddr2_ctrl_model.sv]
// Controller model: free-running memory clock and command pins.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/100ps

module ddr2_ctrl_model #(
  parameter int STABLE_CLKS = 1250
) (
  // Memory clock and command pins
  output logic link_clk,
  output sdram_init_pkg::cmd_pins_s pins
);
  int rises = 0; // Clock rises since power-on
  logic cke_lvl = 1'b0; // Clock enable level to present
  sdram_init_pkg::cmd_pins_s last; // Last command sent

  // Power-on: clock enable low, command pins deselected
  initial begin
    link_clk = 1'b0;
    pins = 22'h1FFFFF;
    last = pins;
  end

  // Clock runs free and stable from power-on
  always #80 link_clk = ~link_clk;
  always @(posedge link_clk) rises <= rises + 1;

  // Idle cycles; don't-care lines show a moving pattern
  task automatic nops(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge link_clk);
      pins.cke = cke_lvl;
      pins.cs_n = 1'b0;
      {pins.ras_n, pins.cas_n, pins.we_n} = 3'h7;
      pins.ba = ~last.ba ^ i[2:0];
      pins.addr = ~last.addr ^ i[13:0];
    end
  endtask : nops

  // Clock enable low, wait for a stable clock, then raise it
  task automatic power_up();
    cke_lvl = 1'b0;
    nops(2);
    wait (rises >= STABLE_CLKS);
    nops(1);
    cke_lvl = 1'b1;
    nops(3);
  endtask : power_up

  // One command held across one clock rise, then idle
  task automatic issue(input logic [2:0] rcw, input logic [2:0] ba,
                       input logic [13:0] a);
    @(negedge link_clk);
    pins.cs_n = 1'b0;
    {pins.ras_n, pins.cas_n, pins.we_n} = rcw;
    pins.ba = ba;
    pins.addr = a;
    last = pins;
    nops(1);
  endtask : issue
endmodule : ddr2_ctrl_model

// [testbench/test_sdram_init_and_mode_register.sv]
// Self-checking bench for the mode register and power-up tracker.
// Assumes the design package and the controller model compile first.
`timescale 1ns/100ps

module test_sdram_init_and_mode_register;
  localparam logic [2:0] MRS = 3'h0, PRE = 3'h2, REF = 3'h1;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic link_clk;
  sdram_init_pkg::cmd_pins_s pins;
  logic [13:0] mode_reg, emr1, mr;
  logic bl8, ilv, tm, bad, dll_en, dll_rdy, done, serr;
  logic [2:0] cl, wr, output_driver_calibration;
  logic [31:0] seed = 32'h6744C191;
  logic [13:0] corner [5] = '{14'h0022, 14'h0E7B, 14'h0031, 14'h0012,
                              14'h00A2};
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  ddr2_ctrl_model #(.STABLE_CLKS(1250)) i_ctrl (.link_clk(link_clk),
    .pins(pins));

  sdram_mode_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .link_clk(link_clk), .pins_in(pins), .mode_reg(mode_reg),
    .burst_len8(bl8), .burst_interleave(ilv), .cas_latency(cl),
    .write_recovery(wr), .test_mode(tm), .bad_mode(bad),
    .dll_enabled(dll_en), .ocd_mode(output_driver_calibration), .dll_ready(dll_rdy),
    .init_done(done), .seq_error(serr));

  // System clock and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      tally_and_finish();
    end
  end

  // Xorshift source, 14 bits at a time
  function automatic logic [13:0] rnd14();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[13:0];
  endfunction : rnd14

  // Unsupported burst length or latency, or test mode
  function automatic logic exp_bad(input logic [13:0] v);
    return !(v[2:0] inside {3'h2, 3'h3}) || v[6:4] < 3'h2 || v[7];
  endfunction : exp_bad

  // Compare one value and count it
  task automatic check(input string what, input logic [13:0] e,
                       input logic [13:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // Write the operating register and check every decoded field
  task automatic write_mode(input logic [13:0] v);
    i_ctrl.issue(MRS, 3'h0, v);
    i_ctrl.nops(1);
    check("mode_reg", v, mode_reg);
    check("burst_len8", 14'(v[2:0] == 3'h3), 14'(bl8));
    check("interleave", 14'(v[3]), 14'(ilv));
    check("cas_latency", 14'(v[6:4]), 14'(cl));
    check("write_rec", 14'(v[11:9]), 14'(wr));
    check("test_mode", 14'(v[7]), 14'(tm));
    check("bad_mode", 14'(exp_bad(v)), 14'(bad));
  endtask : write_mode

  // Precharge all; bank and other address bits are drawn at random
  task automatic pre_all();
    logic [13:0] r;
    r = rnd14();
    i_ctrl.issue(PRE, r[2:0], r | 14'h0400);
  endtask : pre_all

  // Auto refresh; bank and address lines are drawn at random
  task automatic refresh();
    logic [13:0] r;
    r = rnd14();
    i_ctrl.issue(REF, r[2:0], r);
  endtask : refresh

  // Precharge, extended writes, DLL reset, precharge, two refreshes
  task automatic early_steps();
    pre_all();
    i_ctrl.issue(MRS, 3'h2, rnd14() & 14'h0080);
    i_ctrl.issue(MRS, 3'h3, 14'h0000);
    i_ctrl.issue(MRS, 3'h1, emr1);
    i_ctrl.nops(1);
    check("dll_enabled", 14'h1, 14'(dll_en));
    i_ctrl.issue(MRS, 3'h0, mr | 14'h0100);
    i_ctrl.nops(1);
    check("dll_ready_rst", 14'h0, 14'(dll_rdy));
    pre_all();
    refresh();
    refresh();
  endtask : early_steps

  // Reset, check cleared outputs, then power up the link
  task automatic do_reset();
    @(negedge clk_sys);
    nrst = 1'b0;
    repeat (16) @(negedge clk_sys);
    check("reset_mode", 14'h0, mode_reg);
    // Cleared extended register one reads back as DLL enabled
    check("reset_flags", 14'h0008, 14'({done, serr, dll_en, output_driver_calibration}));
    nrst = 1'b1;
    i_ctrl.power_up();
  endtask : do_reset

  // Print counts and verdict, then stop
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    do_reset();
    // Full sequence, minimum refreshes, calibration default then exit
    emr1 = rnd14() & 14'h1C7E;
    mr = (rnd14() & 14'h0E79) | 14'h0022;
    early_steps();
    write_mode(mr);
    check("init_early", 14'h0, 14'(done));
    i_ctrl.nops(175);
    check("dll_ready_early", 14'h0, 14'(dll_rdy));
    i_ctrl.nops(25);
    check("dll_ready", 14'h1, 14'(dll_rdy));
    i_ctrl.issue(MRS, 3'h1, emr1 | 14'h0380);
    i_ctrl.nops(1);
    check("ocd_default", 14'h7, 14'(output_driver_calibration));
    check("init_mid", 14'h0, 14'(done));
    i_ctrl.issue(MRS, 3'h1, emr1);
    i_ctrl.nops(1);
    check("ocd_exit", 14'h0, 14'(output_driver_calibration));
    check("done_error", 14'h2, 14'({done, serr}));
    $display("test init_sequence done");
    // Re-programming after ready, corners then random values
    foreach (corner[i]) write_mode(corner[i]);
    repeat (12) write_mode(rnd14() & 14'h3EFF);
    check("still_done", 14'h2, 14'({done, serr}));
    $display("test reprogram done");
    // Out-of-order command after a mid-run reset
    do_reset();
    i_ctrl.issue(MRS, 3'h2, 14'h0000);
    i_ctrl.nops(1);
    check("skip_prea", 14'h1, 14'({done, serr}));
    // Mode write to a bank code outside the register set
    do_reset();
    pre_all();
    i_ctrl.issue(MRS, 3'h5, 14'h0022);
    i_ctrl.nops(1);
    check("bad_bank", 14'h1, 14'({done, serr}));
    check("bad_bank_mode", 14'h0, mode_reg);
    // Calibration step issued before the DLL has settled
    do_reset();
    early_steps();
    write_mode(mr);
    check("rushed_clean", 14'h0, 14'({done, serr}));
    i_ctrl.issue(MRS, 3'h1, emr1 | 14'h0380);
    i_ctrl.nops(1);
    check("ocd_too_early", 14'h1, 14'({done, serr}));
    $display("test errors done");
    tally_and_finish();
  end
endmodule : test_sdram_init_and_mode_register
